/* rtl/wwdt_pkg.sv */
// Constants, field positions and types shared by the windowed watchdog.
package wwdt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PRE_W  = 7;
  localparam int POST_W = 15;
  localparam int POS_W  = 22;

  // Register offsets.
  localparam logic [ADDR_W-1:0] WWDT_CFG_ADDR  = 8'h00;
  localparam logic [ADDR_W-1:0] WWDT_RSTC_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] WWDT_STAT_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] WWDT_MASK_ADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] WWDT_CNT_ADDR  = 8'h10;

  // Configuration word fields.
  localparam int CFG_HARD_EN  = 7;
  localparam int CFG_WIN_OFF  = 6;
  localparam int CFG_PRE_SEL  = 4;
  localparam int CFG_POST_LSB = 0;
  localparam logic [DATA_W-1:0] CFG_RESET    = 16'h00df;
  localparam logic [DATA_W-1:0] CFG_WR_MASK  = 16'h00df;

  // Reset control register fields.
  localparam int RC_SOFT_EN = 5;
  localparam int RC_TIMEOUT = 4;
  localparam int RC_SLEEP   = 3;
  localparam int RC_IDLE    = 2;

  // Interrupt status and mask fields.
  localparam int EV_W       = 3;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_WAKE    = 1;
  localparam int EV_EARLY   = 2;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

  // Prescaler terminal counts and widths.
  localparam logic [PRE_W-1:0] PRE_TOP_SHORT  = 7'h1f;
  localparam logic [PRE_W-1:0] PRE_TOP_LONG   = 7'h7f;
  localparam logic [2:0]       PRE_BITS_SHORT = 3'h5;
  localparam logic [2:0]       PRE_BITS_LONG  = 3'h7;
  localparam logic [4:0]       QUARTER_SHIFT  = 5'h2;
  localparam logic [POS_W-1:0] WINDOW_FRAC    = 22'h000003;

  // Timing of the low-power RC clock against the system clock.
  localparam int RC_PERIOD_NS  = 31250;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RC_CYCLES     = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RC_CNT_W      = 13;

  typedef enum logic [1:0]
  {
    WWDT_RUN   = 2'b00,
    WWDT_IDLE  = 2'b01,
    WWDT_SLEEP = 2'b11
  } wwdt_pwr_t;

endpackage

/* rtl/wwdt_cnt_if.sv */
// Signals shared by the watchdog control and its two counter stages.
`timescale 1ns/1ps
interface wwdt_cnt_if;
  import wwdt_pkg::*;

  logic              clear;
  logic              tick;
  logic              pre_long;
  logic [3:0]        post_sel;
  logic [PRE_W-1:0]  pre_cnt;
  logic              pre_tc;
  logic [POST_W-1:0] post_cnt;
  logic              timeout;

  modport pre  (input clear, tick, pre_long, output pre_cnt, pre_tc);
  modport post (input clear, pre_tc, post_sel, output post_cnt, timeout);
  modport ctrl (output clear, tick, pre_long, post_sel,
                input pre_cnt, pre_tc, post_cnt, timeout);
endinterface

/* rtl/wwdt_prescaler.sv */
// Divide-by-32 or divide-by-128 prescaler on the RC clock ticks.
`timescale 1ns/1ps
module wwdt_prescaler
  import wwdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  wwdt_cnt_if.pre  cnt
);

  logic [PRE_W-1:0] pre_top;

  assign pre_top    = cnt.pre_long ? PRE_TOP_LONG : PRE_TOP_SHORT;
  assign cnt.pre_tc = cnt.tick && (cnt.pre_cnt == pre_top);

  always_ff @(posedge sys_clk)
  begin
    if (reset || cnt.clear)
      cnt.pre_cnt <= '0;
    else if (cnt.pre_tc)
      cnt.pre_cnt <= '0;
    else if (cnt.tick)
      cnt.pre_cnt <= cnt.pre_cnt + 7'h01;
  end

endmodule

/* rtl/wwdt_postscaler.sv */
// Power-of-two postscaler; its terminal count is the watchdog time-out.
`timescale 1ns/1ps
module wwdt_postscaler
  import wwdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  wwdt_cnt_if.post cnt
);

  logic [POST_W-1:0] post_top;

  assign post_top    = (15'h0001 << cnt.post_sel) - 15'h0001;
  assign cnt.timeout = cnt.pre_tc && (cnt.post_cnt == post_top);

  always_ff @(posedge sys_clk)
  begin
    if (reset || cnt.clear)
      cnt.post_cnt <= '0;
    else if (cnt.timeout)
      cnt.post_cnt <= '0;
    else if (cnt.pre_tc)
      cnt.post_cnt <= cnt.post_cnt + 15'h0001;
  end

endmodule

/* rtl/wwdt_top.sv */
// Windowed watchdog timer: registers, power-save tracking and reset logic.
//
// Summary of operation
// - The watchdog runs from the RC clock, which is on while it is enabled.
// - The prescaler divides the RC clock by 32 or 128 per the select bit.
// - At a nominal 32 kHz the prescaler period is about 1 ms or 4 ms.
// - A postscaler divides further by one of 16 ratios from the low nibble.
// - Reset, clock switch, power-save change and clear zero all counts.
// - In sleep and idle the watchdog keeps counting and a time-out wakes.
// - With hard enable set the watchdog always runs.
// - A time-out in run mode sets a sticky flag that only software clears.
// - With hard enable clear, only a set soft enable runs the watchdog.
// - Every device reset clears the soft enable bit.
// - In window mode a clear before the last quarter resets the device.
// - Prescale select 1 means divide by 128 and 0 means divide by 32.
// - Postscale 0000 is 1:1 and each step doubles, up to 1111 at 1:32,768.
// - Window-off 1 accepts a clear at any time and 0 selects window mode.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int RC_DIV = RC_CYCLES
)
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              watchdog_clear_instr,
  input  wire logic              power_save_instr,
  input  wire logic              power_save_sleep,
  input  wire logic              wake_event,
  input  wire logic              clock_switch_done,
  input  wire logic              dev_reset_in,
  output logic                   low_power_rc_osc,
  output logic                   wd_device_reset,
  output logic                   wd_wake,
  output logic                   irq
);

  wwdt_cnt_if cnt ();

  logic [DATA_W-1:0]     watchdog_config_word;
  logic                  cfg_locked;
  logic                  wd_soft_enable;
  logic                  wd_timeout_flag;
  logic                  sleep_flag;
  logic                  idle_flag;
  logic [EV_W-1:0]       int_status;
  logic [EV_W-1:0]       int_mask;
  logic [RC_CNT_W-1:0]   rc_cnt;
  wwdt_pwr_t             pwr;

  logic              wd_hard_enable;
  logic              window_mode_off;
  logic              wd_prescale_select;
  logic [3:0]        wd_postscale_select;
  logic              wd_enabled;
  logic              running;
  logic              enter_ps;
  logic              clr_run;
  logic              window_open;
  logic              early_clear;
  logic              run_timeout;
  logic              sleep_timeout;
  logic              trip;
  logic              dev_reset_any;
  logic              exit_ps;
  logic              wr_rstc;
  logic [2:0]        pre_bits;
  logic [4:0]        total_bits;
  logic [POS_W-1:0]  position;
  logic [POS_W-1:0]  window_start;
  logic [EV_W-1:0]   events;
  logic [DATA_W-1:0] next_rd_data;

  assign wd_hard_enable      = watchdog_config_word[CFG_HARD_EN];
  assign window_mode_off     = watchdog_config_word[CFG_WIN_OFF];
  assign wd_prescale_select  = watchdog_config_word[CFG_PRE_SEL];
  assign wd_postscale_select = watchdog_config_word[CFG_POST_LSB +: 4];

  assign wd_enabled = wd_hard_enable || wd_soft_enable;
  assign running    = (pwr == WWDT_RUN);

  // The RC oscillator runs only while the watchdog is enabled.
  assign low_power_rc_osc = wd_enabled;

  always_ff @(posedge sys_clk)
  begin
    if (reset || !wd_enabled)
      rc_cnt <= '0;
    else if (rc_cnt == RC_CNT_W'(RC_DIV - 1))
      rc_cnt <= '0;
    else
      rc_cnt <= rc_cnt + 13'h0001;
  end

  assign cnt.tick = low_power_rc_osc &&
                    (rc_cnt == RC_CNT_W'(RC_DIV - 1));
  assign cnt.pre_long = wd_prescale_select;
  assign cnt.post_sel = wd_postscale_select;

  wwdt_prescaler u_pre
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cnt     (cnt.pre)
  );

  wwdt_postscaler u_post
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cnt     (cnt.post)
  );

  // Position in the period, in RC ticks, against the start of the window.
  assign pre_bits     = wd_prescale_select ? PRE_BITS_LONG : PRE_BITS_SHORT;
  assign total_bits   = {2'h0, pre_bits} + {1'h0, wd_postscale_select};
  assign position     = ({7'h00, cnt.post_cnt} << pre_bits) |
                        {15'h0000, cnt.pre_cnt};
  assign window_start = WINDOW_FRAC << (total_bits - QUARTER_SHIFT);
  assign window_open  = (position >= window_start);

  assign clr_run     = watchdog_clear_instr && running && wd_enabled;
  assign early_clear = clr_run && !window_mode_off &&
                       !window_open;
  assign run_timeout   = cnt.timeout && running;
  assign sleep_timeout = cnt.timeout && !running;
  assign trip          = run_timeout || early_clear;
  assign enter_ps      = power_save_instr && running;
  assign exit_ps       = !running && (sleep_timeout || wake_event);
  assign dev_reset_any = dev_reset_in || trip;

  // Every event that restarts the count from zero.
  assign cnt.clear = !wd_enabled || dev_reset_any || clock_switch_done ||
                     enter_ps || exit_ps || watchdog_clear_instr;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pwr <= WWDT_RUN;
    else if (dev_reset_any || exit_ps)
      pwr <= WWDT_RUN;
    else if (enter_ps)
      pwr <= power_save_sleep ? WWDT_SLEEP : WWDT_IDLE;
    else
    begin
      case (pwr)
        WWDT_RUN:   pwr <= WWDT_RUN;
        WWDT_IDLE:  pwr <= WWDT_IDLE;
        WWDT_SLEEP: pwr <= WWDT_SLEEP;
        default:    pwr <= WWDT_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wd_device_reset <= 1'b0;
      wd_wake         <= 1'b0;
    end
    else
    begin
      wd_device_reset <= trip;
      wd_wake         <= sleep_timeout;
    end
  end

  // The configuration word takes one write per power cycle.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      watchdog_config_word <= CFG_RESET;
      cfg_locked           <= 1'b0;
    end
    else if (wr_en && addr == WWDT_CFG_ADDR && !cfg_locked)
    begin
      watchdog_config_word <= wr_data & CFG_WR_MASK;
      cfg_locked           <= 1'b1;
    end
  end

  assign wr_rstc = wr_en && (addr == WWDT_RSTC_ADDR);

  always_ff @(posedge sys_clk)
  begin
    if (reset || dev_reset_any)
      wd_soft_enable <= 1'b0;
    else if (wr_rstc)
      wd_soft_enable <= wr_data[RC_SOFT_EN];
  end

  // Hardware sets win over a software clear in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      wd_timeout_flag <= 1'b0;
    else if (trip)
      wd_timeout_flag <= 1'b1;
    else if (wr_rstc && !wr_data[RC_TIMEOUT])
      wd_timeout_flag <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sleep_flag <= 1'b0;
      idle_flag  <= 1'b0;
    end
    else
    begin
      if (enter_ps && power_save_sleep)
        sleep_flag <= 1'b1;
      else if (wr_rstc && !wr_data[RC_SLEEP])
        sleep_flag <= 1'b0;
      if (enter_ps && !power_save_sleep)
        idle_flag <= 1'b1;
      else if (wr_rstc && !wr_data[RC_IDLE])
        idle_flag <= 1'b0;
    end
  end

  assign events = {early_clear, sleep_timeout, run_timeout};

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      int_status <= '0;
    else if (rd_en && addr == WWDT_STAT_ADDR)
      int_status <= events;
    else
      int_status <= int_status | events;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      int_mask <= MASK_RESET;
    else if (wr_en && addr == WWDT_MASK_ADDR)
      int_mask <= wr_data[EV_W-1:0];
  end

  assign irq = |(int_status & int_mask);

  always_comb
  begin
    next_rd_data = '0;
    case (addr)
      WWDT_CFG_ADDR:  next_rd_data = watchdog_config_word;
      WWDT_RSTC_ADDR:
      begin
        next_rd_data[RC_SOFT_EN] = wd_soft_enable;
        next_rd_data[RC_TIMEOUT] = wd_timeout_flag;
        next_rd_data[RC_SLEEP]   = sleep_flag;
        next_rd_data[RC_IDLE]    = idle_flag;
      end
      WWDT_STAT_ADDR: next_rd_data[EV_W-1:0] = int_status;
      WWDT_MASK_ADDR: next_rd_data[EV_W-1:0] = int_mask;
      WWDT_CNT_ADDR:  next_rd_data[POST_W-1:0] = cnt.post_cnt;
      default:        next_rd_data = '0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= next_rd_data;
    else
      rd_data <= '0;
  end

  a_osc_on_tick: assert property (
    @(posedge sys_clk) disable iff (reset)
    cnt.tick |-> low_power_rc_osc ##1 !cnt.tick)
    else $error("RC tick with the oscillator off or back to back");

  a_pre_wrap_point: assert property (
    @(posedge sys_clk) disable iff (reset)
    cnt.pre_tc |-> cnt.pre_cnt == (wd_prescale_select ? 7'h7f : 7'h1f))
    else $error("Prescaler wrapped at the wrong count");

  a_post_terminal: assert property (
    @(posedge sys_clk) disable iff (reset)
    cnt.timeout |-> cnt.pre_tc &&
      cnt.post_cnt == (15'h0001 << wd_postscale_select) - 15'h0001)
    else $error("Time-out not at the postscaler terminal count");

  a_clear_counts: assert property (
    @(posedge sys_clk) disable iff (reset)
    (clock_switch_done || dev_reset_in || enter_ps ||
     watchdog_clear_instr) |=>
      cnt.pre_cnt == 7'h00 && cnt.post_cnt == 15'h0000)
    else $error("Counters not cleared after a clearing event");

  a_sleep_wakes: assert property (
    @(posedge sys_clk) disable iff (reset)
    (cnt.timeout && !running) |=> wd_wake && !wd_device_reset && running)
    else $error("Power-save time-out did not wake the core");

  a_hard_runs: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wd_hard_enable && !(wr_en && addr == WWDT_CFG_ADDR && !cfg_locked))
      |=> wd_hard_enable && low_power_rc_osc)
    else $error("Hard-enabled watchdog stopped");

  a_flag_sticky: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wd_timeout_flag && !(wr_rstc && !wr_data[RC_TIMEOUT])) |=>
      wd_timeout_flag)
    else $error("Time-out flag dropped without a software clear");

  a_soft_gate: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!wd_hard_enable && !wd_soft_enable) |=> cnt.post_cnt == 15'h0000 [*2])
    else $error("Watchdog counted while disabled");

  a_soft_cleared: assert property (
    @(posedge sys_clk) disable iff (reset)
    dev_reset_in |=> !wd_soft_enable)
    else $error("Soft enable survived a device reset");

  a_early_trip: assert property (
    @(posedge sys_clk) disable iff (reset)
    (clr_run && !window_mode_off && !window_open) |=> wd_device_reset)
    else $error("Early clear in window mode did not reset");

  a_run_timeout: assert property (
    @(posedge sys_clk) disable iff (reset)
    (cnt.timeout && running) |=>
      wd_device_reset && wd_timeout_flag && !wd_wake)
    else $error("Running time-out did not reset and flag");

endmodule

/* bench/tb.sv */
// Self-checking testbench for the windowed watchdog top module.
`timescale 1ns/1ps
module tb;
  import wwdt_pkg::*;

  localparam int         DIV = 2;
  localparam logic [7:0] CTL = WWDT_RSTC_ADDR;

  typedef struct
  {
    logic [15:0] cfg;
    int          cyc;
  } wwdt_row_t;

  logic              sys_clk;
  logic              reset;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [4:0]        ev;
  logic              power_save_sleep;
  logic              low_power_rc_osc;
  logic              wd_device_reset;
  logic              wd_wake;
  logic              irq;
  int                failures;
  int                cmp_count;
  int                rst_seen;
  int                n;
  int                k;
  logic [15:0]       d;
  wwdt_row_t         rows [11];

  wwdt_top #(.RC_DIV(DIV)) dut_u
  (
    .sys_clk,
    .reset,
    .addr,
    .wr_data,
    .wr_en,
    .rd_en,
    .rd_data,
    .watchdog_clear_instr (ev[0]),
    .power_save_instr     (ev[1]),
    .power_save_sleep,
    .wake_event           (ev[2]),
    .clock_switch_done    (ev[3]),
    .dev_reset_in         (ev[4]),
    .low_power_rc_osc,
    .wd_device_reset,
    .wd_wake,
    .irq
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Counts reset pulses so that a missing or extra one can be caught.
  always @(posedge sys_clk)
    if (wd_device_reset === 1'b1)
      rst_seen++;

  task automatic finish_test();
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic near(input int got, input int want);
    check(16'(got >= want - DIV - 2 && got <= want + DIV + 2), 16'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  // Core event pulse: 0 clear, 1 power save, 2 wake, 3 clock switch, 4 reset.
  task automatic pulse(input int sel);
    @(posedge sys_clk);
    ev <= 5'h01 << sel;
    @(posedge sys_clk);
    ev <= 5'h00;
  endtask

  task automatic wait_ev(input bit wake, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge sys_clk);
      #1 cnt++;
    end
    while (((wake ? wd_wake : wd_device_reset) !== 1'b1) && cnt < lim);
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
  endtask

  initial
  begin
    repeat (80000) @(posedge sys_clk);
    failures++;
    finish_test();
  end

  initial
  begin
    addr = 8'h00;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ev = 5'h00;
    power_save_sleep = 1'b0;
    reset = 1'b1;
    for (int i = 0; i < 9; i++)
      rows[i] = '{16'h00c0 | 16'(i), (DIV * 32) << i};
    for (int i = 0; i < 2; i++)
      rows[9 + i] = '{16'h00d0 | 16'(i), (DIV * 128) << i};
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    #1 check(low_power_rc_osc, 1'b1);
    check(irq, 1'b0);
    rd(WWDT_CFG_ADDR, d);
    check(d, CFG_RESET);
    rd(WWDT_MASK_ADDR, d);
    check(d, 16'(MASK_RESET));
    wr(8'h3c, 16'hffff);
    rd(8'h3c, d);
    check(d, 16'h0000);
    foreach (rows[i])
    begin
      do_reset();
      wr(WWDT_CFG_ADDR, rows[i].cfg);
      wr(WWDT_CFG_ADDR, 16'h0000);
      pulse(0);
      wait_ev(0, rows[i].cyc * 2 + 20, n);
      near(n, rows[i].cyc);
    end
    rd(CTL, d);
    check(d & 16'h0010, 16'h0010);
    rd(WWDT_STAT_ADDR, d);
    check(d & 16'h0007, 16'h0001);
    rd(WWDT_STAT_ADDR, d);
    check(d, 16'h0000);
    rd(CTL, d);
    check(d & 16'h0010, 16'h0010);
    wr(CTL, 16'h0000);
    rd(CTL, d);
    check(d & 16'h0010, 16'h0000);

    do_reset();
    wr(WWDT_CFG_ADDR, 16'h0040);
    pulse(0);
    #1 check(low_power_rc_osc, 1'b0);
    k = rst_seen;
    repeat (200) @(posedge sys_clk);
    check(16'(rst_seen - k), 16'h0);
    rd(WWDT_CNT_ADDR, d);
    check(d, 16'h0000);
    wr(CTL, 16'h0020);
    #1 check(low_power_rc_osc, 1'b1);
    wait_ev(0, 200, n);
    near(n, DIV * 32);
    rd(CTL, d);
    check(d & 16'h0030, 16'h0010);
    wr(CTL, 16'h0020);
    pulse(0);
    repeat (40) @(posedge sys_clk);
    pulse(3);
    wait_ev(0, 200, n);
    near(n, DIV * 32);
    wr(CTL, 16'h0020);
    pulse(4);
    rd(CTL, d);
    check(d & 16'h0020, 16'h0000);

    do_reset();
    wr(WWDT_CFG_ADDR, 16'h0082);
    wr(CTL, 16'h0000);
    wait_ev(0, 600, n);
    check(wd_device_reset, 1'b1);
    repeat (210) @(posedge sys_clk);
    k = rst_seen;
    pulse(0);
    repeat (20) @(posedge sys_clk);
    pulse(0);
    #1 check(wd_device_reset, 1'b1);
    @(posedge sys_clk);
    #1 check(16'(rst_seen - k), 16'h1);
    rd(WWDT_STAT_ADDR, d);
    check(d & 16'h0004, 16'h0004);

    do_reset();
    wr(WWDT_CFG_ADDR, 16'h00c0);
    wr(WWDT_MASK_ADDR, 16'h0007);
    power_save_sleep <= 1'b1;
    k = rst_seen;
    pulse(1);
    wait_ev(1, 200, n);
    near(n, DIV * 32);
    @(posedge sys_clk);
    #1 check(16'(rst_seen - k), 16'h0);
    check(irq, 1'b1);
    rd(CTL, d);
    check(d & 16'h0018, 16'h0008);
    wr(CTL, 16'h0000);
    rd(CTL, d);
    check(d & 16'h0008, 16'h0000);
    rd(WWDT_STAT_ADDR, d);
    check(d & 16'h0007, 16'h0002);
    check(irq, 1'b0);
    power_save_sleep <= 1'b0;
    pulse(1);
    repeat (30) @(posedge sys_clk);
    pulse(2);
    wait_ev(0, 200, n);
    near(n, DIV * 32);
    rd(CTL, d);
    check(d & 16'h0004, 16'h0004);
    @(posedge sys_clk);
    #1 check(irq, 1'b1);
    wr(WWDT_MASK_ADDR, 16'h0000);
    #1 check(irq, 1'b0);
    finish_test();
  end
endmodule
